// ==== src/sbdc_consts.svh ====
// Register offsets, field positions, reset values and timing figures of the SYSREF bank
`ifndef SBDC_CONSTS_SVH
`define SBDC_CONSTS_SVH
`define SBDC_ADDR_POWER 8'h18
`define SBDC_ADDR_BIAS_DLY 8'h19
`define SBDC_ADDR_FB_LOW 8'h1a
`define SBDC_ADDR_IN_DIV 8'h1b
`define SBDC_BIT_POWERDOWN 7
`define SBDC_BIT_BIAS_TYPE 7
`define SBDC_MULT_MSB 6
`define SBDC_MULT_LSB 5
`define SBDC_BIT_FB_MSB 0
`define SBDC_BIT_ALIGN_SEL 7
`define SBDC_RST_POWERDOWN 1'h0
`define SBDC_RST_BIAS_TYPE 1'h0
`define SBDC_RST_MULT 2'h0
`define SBDC_RST_FB_DIV 9'h010
`define SBDC_RST_IN_DIV 7'h08
`define SBDC_RST_ALIGN_SEL 1'h0
`define SBDC_OSC_KHZ 983040
`define SBDC_STEP_DIVISOR 8
`define SBDC_BASE_STEP_PS 10'h083
`define SBDC_ALIGN_DIV_LOW 6'h18
`define SBDC_ALIGN_DIV_HIGH 6'h30
`endif

// ==== src/sbdc_pkg.sv ====
// Types shared by the SYSREF bias and delay control bank
package sbdc_pkg;
  typedef enum logic [1:0] {
    SBDC_IDLE = 2'b00,
    SBDC_RUN = 2'b01
  } sbdc_stage_e;

  typedef struct packed {
    logic powered;
    logic crosspoint;
    logic q_true;
    logic q_comp;
  } sbdc_drive_s;

  typedef struct packed {
    logic powerdown;
    logic bias_type;
    logic [1:0] delay_unit_multiplier;
  } sbdc_ctrl_s;
endpackage

// ==== src/sbdc_out_stage.sv ====
// One SYSREF output leg pair: idle level, start on first rising edge, static modes
`timescale 1ns/1ns
`include "sbdc_consts.svh"
module sbdc_out_stage
  import sbdc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire sbdc_ctrl_s ctrl_in,
  input wire logic bias_bit_in,
  input wire logic lvpecl_in,
  input wire logic sref_level_in,
  input wire logic sref_rise_in,
  output sbdc_stage_e state_out,
  output sbdc_drive_s drive_out
);
  sbdc_stage_e state_reg;
  sbdc_drive_s drive_reg;
  logic lvds_bias;
  logic static_hold;

  // Bias bits only shape LVDS outputs
  assign lvds_bias = ~lvpecl_in & ctrl_in.bias_type;
  assign static_hold = ~lvpecl_in & bias_bit_in;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg <= SBDC_IDLE;
    end else begin
      case (state_reg)
        SBDC_IDLE: begin
          if (!ctrl_in.powerdown && sref_rise_in && !static_hold) begin
            state_reg <= SBDC_RUN;
          end
        end
        SBDC_RUN: begin
          if (ctrl_in.powerdown || static_hold) begin
            state_reg <= SBDC_IDLE;
          end
        end
        default: state_reg <= SBDC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      drive_reg <= '{powered: 1'b1, crosspoint: 1'b0, q_true: 1'b0, q_comp: 1'b1};
    end else if (ctrl_in.powerdown) begin
      drive_reg <= '{powered: 1'b0, crosspoint: 1'b0, q_true: 1'b0, q_comp: 1'b1};
    end else if (state_reg == SBDC_RUN && !static_hold) begin
      drive_reg <= '{powered: 1'b1, crosspoint: 1'b0, q_true: sref_level_in,
                     q_comp: ~sref_level_in};
    end else if (lvds_bias) begin
      drive_reg <= '{powered: 1'b1, crosspoint: 1'b1, q_true: 1'b0, q_comp: 1'b0};
    end else begin
      drive_reg <= '{powered: 1'b1, crosspoint: 1'b0, q_true: 1'b0, q_comp: 1'b1};
    end
  end

  assign state_out = state_reg;
  assign drive_out = drive_reg;
endmodule

// ==== src/sbdc_bank.sv ====
// SYSREF power, bias type, delay unit and calibration divider register bank
`timescale 1ns/1ns
`include "sbdc_consts.svh"
module sbdc_bank
  import sbdc_pkg::*;
#(
  parameter int NUM_OUT = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  input wire logic sref_pin_in,
  input wire logic [NUM_OUT-1:0] out_bias_in,
  input wire logic [NUM_OUT-1:0] out_lvpecl_in,
  output sbdc_drive_s [NUM_OUT-1:0] drive_out,
  output logic [2:0] delay_mult_out,
  output logic [9:0] delay_step_ps_out,
  output logic [8:0] cal_feedback_divider_out,
  output logic [6:0] cal_input_divider_out,
  output logic [5:0] align_ref_div_out
);
  if (NUM_OUT < 1 || NUM_OUT > 16) begin : g_bad_num_out
    $error("NUM_OUT must be 1 to 16");
  end

  sbdc_ctrl_s ctrl_reg;
  logic [8:0] fb_div_reg;
  logic [6:0] in_div_reg;
  logic align_sel_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic sref_meta_reg;
  logic sref_sync_reg;
  logic sref_prev_reg;
  logic sref_rise;
  sbdc_stage_e [NUM_OUT-1:0] stage_state;

  // Power, bias type, delay multiplier and feedback divider in one shared process
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctrl_reg.powerdown <= `SBDC_RST_POWERDOWN;
      ctrl_reg.bias_type <= `SBDC_RST_BIAS_TYPE;
      ctrl_reg.delay_unit_multiplier <= `SBDC_RST_MULT;
      fb_div_reg <= `SBDC_RST_FB_DIV;
    end else if (cfg_wr_in) begin
      case (cfg_addr_in)
        `SBDC_ADDR_POWER: begin
          ctrl_reg.powerdown <= cfg_wdata_in[`SBDC_BIT_POWERDOWN];
        end
        `SBDC_ADDR_BIAS_DLY: begin
          ctrl_reg.bias_type <= cfg_wdata_in[`SBDC_BIT_BIAS_TYPE];
          ctrl_reg.delay_unit_multiplier <= cfg_wdata_in[`SBDC_MULT_MSB:`SBDC_MULT_LSB];
          fb_div_reg[8] <= cfg_wdata_in[`SBDC_BIT_FB_MSB];
        end
        `SBDC_ADDR_FB_LOW: begin
          fb_div_reg[7:0] <= cfg_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  // Align divider select and input divider
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      align_sel_reg <= `SBDC_RST_ALIGN_SEL;
      in_div_reg <= `SBDC_RST_IN_DIV;
    end else if (cfg_wr_in && cfg_addr_in == `SBDC_ADDR_IN_DIV) begin
      align_sel_reg <= cfg_wdata_in[`SBDC_BIT_ALIGN_SEL];
      in_div_reg <= cfg_wdata_in[6:0];
    end
  end

  // Read mux, reserved bits and unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    case (cfg_addr_in)
      `SBDC_ADDR_POWER: rdata_next[`SBDC_BIT_POWERDOWN] = ctrl_reg.powerdown;
      `SBDC_ADDR_BIAS_DLY: begin
        rdata_next = {ctrl_reg.bias_type, ctrl_reg.delay_unit_multiplier, 4'h0, fb_div_reg[8]};
      end
      `SBDC_ADDR_FB_LOW: rdata_next = fb_div_reg[7:0];
      `SBDC_ADDR_IN_DIV: rdata_next = {align_sel_reg, in_div_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_reg <= 8'h00;
    end else if (cfg_rd_in) begin
      rdata_reg <= rdata_next;
    end
  end

  // SYSREF input synchroniser and rising edge
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sref_meta_reg <= 1'b0;
      sref_sync_reg <= 1'b0;
      sref_prev_reg <= 1'b0;
    end else begin
      sref_meta_reg <= sref_pin_in;
      sref_sync_reg <= sref_meta_reg;
      sref_prev_reg <= sref_sync_reg;
    end
  end

  assign sref_rise = sref_sync_reg & ~sref_prev_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      sbdc_out_stage u_stage (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ctrl_in(ctrl_reg),
        .bias_bit_in(out_bias_in[gi]),
        .lvpecl_in(out_lvpecl_in[gi]),
        .sref_level_in(sref_sync_reg),
        .sref_rise_in(sref_rise),
        .state_out(stage_state[gi]),
        .drive_out(drive_out[gi])
      );
    end
  endgenerate

  // Delay step in ps scales the base unit by 1 + multiplier
  assign delay_mult_out = 3'(ctrl_reg.delay_unit_multiplier) + 3'h1;
  assign delay_step_ps_out = 10'(`SBDC_BASE_STEP_PS * delay_mult_out);
  assign cal_feedback_divider_out = fb_div_reg;
  assign cal_input_divider_out = in_div_reg;
  assign align_ref_div_out = align_sel_reg ? `SBDC_ALIGN_DIV_HIGH : `SBDC_ALIGN_DIV_LOW;
  assign cfg_rdata_out = rdata_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Delay step per multiplier code
  chk_step_131: assert property (
      ctrl_reg.delay_unit_multiplier == 2'h0 |-> delay_step_ps_out == 10'd131)
    else $error("delay step not 131 ps at code 00");
  chk_step_262: assert property (
      ctrl_reg.delay_unit_multiplier == 2'h1 |-> delay_step_ps_out == 10'd262)
    else $error("delay step not 262 ps at code 01");
  chk_step_formula: assert property (
      delay_step_ps_out == 10'(131 * (ctrl_reg.delay_unit_multiplier + 1)))
    else $error("delay step does not scale with multiplier");

  // Register port
  chk_pd_write: assert property (
      cfg_wr_in && cfg_addr_in == 8'h18 |=> ctrl_reg.powerdown == $past(cfg_wdata_in[7]))
    else $error("powerdown bit did not take written value");
  chk_bias_write: assert property (
      cfg_wr_in && cfg_addr_in == 8'h19 |=> ctrl_reg.bias_type == $past(cfg_wdata_in[7])
      && ctrl_reg.delay_unit_multiplier == $past(cfg_wdata_in[6:5]))
    else $error("bias type or multiplier did not take written value");
  chk_fb_write: assert property (
      cfg_wr_in && cfg_addr_in == 8'h1a
      |=> cal_feedback_divider_out[7:0] == $past(cfg_wdata_in))
    else $error("feedback divider low byte did not take written value");
  chk_div_write: assert property (
      cfg_wr_in && cfg_addr_in == 8'h1b |=> cal_input_divider_out == $past(cfg_wdata_in[6:0])
      && align_sel_reg == $past(cfg_wdata_in[7]))
    else $error("input divider or align select did not take written value");
  chk_mult_read: assert property (
      cfg_rd_in && cfg_addr_in == 8'h19
      |=> cfg_rdata_out[6:5] == $past(ctrl_reg.delay_unit_multiplier))
    else $error("multiplier read back wrong");

  // Output stages
  chk_pd_drive: assert property (
      ctrl_reg.powerdown |=> !drive_out[0].powered)
    else $error("output stayed powered during powerdown");
  chk_pd_idle: assert property (
      ctrl_reg.powerdown |=> stage_state[0] == SBDC_IDLE)
    else $error("output kept running during powerdown");
  chk_static_hold: assert property (
      out_bias_in[0] && !out_lvpecl_in[0] |=> stage_state[0] == SBDC_IDLE)
    else $error("disabled LVDS output started switching");
  chk_static_low: assert property (
      !ctrl_reg.bias_type && out_bias_in[0] && !out_lvpecl_in[0] && !ctrl_reg.powerdown
      ##1 $stable(out_bias_in[0]) && $stable(ctrl_reg)
      |-> !drive_out[0].q_true && drive_out[0].q_comp && !drive_out[0].crosspoint)
    else $error("disabled output not static low");
  chk_static_cross: assert property (
      ctrl_reg.bias_type && out_bias_in[0] && !out_lvpecl_in[0] && !ctrl_reg.powerdown
      ##1 $stable(out_bias_in[0]) && $stable(ctrl_reg)
      |-> drive_out[0].crosspoint)
    else $error("output left crosspoint in static mode");
  chk_park_cross: assert property (
      $fell(ctrl_reg.powerdown) && ctrl_reg.bias_type && !out_bias_in[0] && !out_lvpecl_in[0]
      |=> drive_out[0].crosspoint)
    else $error("output not parked at crosspoint after powerdown pulse");
  chk_lvpecl_ignore: assert property (
      out_lvpecl_in[NUM_OUT-1] && !ctrl_reg.powerdown && stage_state[NUM_OUT-1] == SBDC_IDLE
      ##1 $stable(out_lvpecl_in[NUM_OUT-1]) |-> !drive_out[NUM_OUT-1].crosspoint)
    else $error("bias select moved an LVPECL output");
  chk_start_rise: assert property (
      stage_state[0] == SBDC_IDLE && sref_rise && !ctrl_reg.powerdown
      && !(out_bias_in[0] && !out_lvpecl_in[0])
      |=> stage_state[0] == SBDC_RUN ##1 drive_out[0].q_true == $past(sref_sync_reg))
    else $error("output did not start on first SYSREF rise");
  chk_idle_level: assert property (
      stage_state[0] == SBDC_IDLE && !ctrl_reg.bias_type && !ctrl_reg.powerdown
      ##1 stage_state[0] == SBDC_IDLE && $stable(ctrl_reg)
      |-> !drive_out[0].q_true && !drive_out[0].crosspoint)
    else $error("idle output not low with bias type 0");
  chk_align_div: assert property (
      align_ref_div_out == (align_sel_reg ? 6'd48 : 6'd24))
    else $error("alignment divider select wrong");

  cov_run_start: cover property (stage_state[0] == SBDC_IDLE ##1 stage_state[0] == SBDC_RUN);
  cov_cross_idle: cover property (drive_out[0].crosspoint ##1 stage_state[0] == SBDC_RUN);
  cov_pd_pulse: cover property (ctrl_reg.powerdown ##1 !ctrl_reg.powerdown);
  cov_static_cross: cover property (ctrl_reg.bias_type && out_bias_in[0]
      && drive_out[0].crosspoint);
  cov_lvpecl_run: cover property (out_lvpecl_in[NUM_OUT-1]
      && stage_state[NUM_OUT-1] == SBDC_RUN);
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench of the SYSREF bias and delay register bank
`timescale 1ns/1ns
module testbench;
  import sbdc_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cfg_wr_in = 1'b0;
  logic cfg_rd_in = 1'b0;
  logic [7:0] cfg_addr_in = 8'h00;
  logic [7:0] cfg_wdata_in = 8'h00;
  logic [7:0] cfg_rdata_out;
  logic sref_pin_in = 1'b0;
  logic [1:0] out_bias_in = 2'h0;
  logic [1:0] out_lvpecl_in = 2'h2;
  sbdc_drive_s [1:0] drive_out;
  logic [2:0] delay_mult_out;
  logic [9:0] delay_step_ps_out;
  logic [8:0] cal_feedback_divider_out;
  logic [6:0] cal_input_divider_out;
  logic [5:0] align_ref_div_out;
  int err_count = 0;
  int n_tests = 0;

  always #5 clk_in = ~clk_in;

  // Output 0 is LVDS, output 1 is LVPECL
  sbdc_bank #(.NUM_OUT(2)) u_sbdc_bank (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .cfg_wr_in(cfg_wr_in),
    .cfg_rd_in(cfg_rd_in),
    .cfg_addr_in(cfg_addr_in),
    .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out),
    .sref_pin_in(sref_pin_in),
    .out_bias_in(out_bias_in),
    .out_lvpecl_in(out_lvpecl_in),
    .drive_out(drive_out),
    .delay_mult_out(delay_mult_out),
    .delay_step_ps_out(delay_step_ps_out),
    .cal_feedback_divider_out(cal_feedback_divider_out),
    .cal_input_divider_out(cal_input_divider_out),
    .align_ref_div_out(align_ref_div_out)
  );

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    @(posedge clk_in);
    cfg_wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge clk_in);
    cfg_rd_in <= 1'b0;
    #1;
    check("rdata", {2'h0, exp}, {2'h0, cfg_rdata_out});
  endtask

  // Pin level and bias bits, then let the synchroniser and stage settle
  task automatic stim(input logic p, input logic [1:0] b);
    @(posedge clk_in);
    sref_pin_in <= p;
    out_bias_in <= b;
    repeat (8) @(posedge clk_in);
    #1;
  endtask

  task automatic dchk(input logic [3:0] e0, input logic [3:0] e1);
    check("drive0", {6'h0, e0}, {6'h0, drive_out[0]});
    check("drive1", {6'h0, e1}, {6'h0, drive_out[1]});
  endtask

  initial begin
    #100000;
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1;
    dchk(4'h9, 4'h9);
    check("step", 10'h083, delay_step_ps_out);
    check("fbdiv", 10'h010, {1'b0, cal_feedback_divider_out});
    check("indiv", 10'h008, {3'h0, cal_input_divider_out});
    check("align", 10'h018, {4'h0, align_ref_div_out});
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h00);
    rd(8'h1a, 8'h10);
    rd(8'h1b, 8'h08);
    wr(8'h1c, 8'hff);
    rd(8'h1c, 8'h00);
    rd(8'h18, 8'h00);
    wr(8'h19, 8'hff);
    rd(8'h19, 8'he1);
    wr(8'h1a, 8'h55);
    check("fbdiv", 10'h155, {1'b0, cal_feedback_divider_out});
    wr(8'h1b, 8'h85);
    rd(8'h1b, 8'h85);
    check("align", 10'h030, {4'h0, align_ref_div_out});
    check("indiv", 10'h005, {3'h0, cal_input_divider_out});
    for (int m = 0; m < 4; m++) begin
      wr(8'h19, {1'b0, 2'(m), 5'h00});
      check("step", 10'((m + 1) * 131), delay_step_ps_out);
      check("mult", 10'(m + 1), {7'h0, delay_mult_out});
    end
    stim(1'b1, 2'h0);
    dchk(4'ha, 4'ha);
    stim(1'b0, 2'h0);
    dchk(4'h9, 4'h9);
    stim(1'b0, 2'h3);
    stim(1'b1, 2'h3);
    dchk(4'h9, 4'ha);
    stim(1'b0, 2'h3);
    wr(8'h19, 8'h80);
    wr(8'h18, 8'h80);
    rd(8'h18, 8'h80);
    stim(1'b1, 2'h3);
    check("powered0", 10'h000, {9'h0, drive_out[0].powered});
    check("drive1", 10'h001, {6'h0, drive_out[1]});
    stim(1'b0, 2'h2);
    wr(8'h18, 8'h00);
    stim(1'b0, 2'h3);
    dchk(4'hc, 4'h9);
    stim(1'b1, 2'h3);
    dchk(4'hc, 4'ha);
    stim(1'b0, 2'h3);
    stim(1'b0, 2'h2);
    dchk(4'hc, 4'h9);
    stim(1'b1, 2'h2);
    dchk(4'ha, 4'ha);
    print_verdict();
  end
endmodule
